//--- logic/t16oc_top.sv
// Two-channel 16-bit timer output compare unit with AHB-Lite register access
`timescale 1ns/10ps
// Function
// - Each channel compares the whole 16-bit counter with its active compare value.
// - Enabled set flag requests an interrupt; servicing it clears the flag.
// - Writing one clears a flag; writing zero leaves it.
// - Channel A's compare value can serve as the counter TOP.
// - PWM modes buffer the compare value; normal and clear-on-match modes bypass.
// - Buffered value reaches the active register only at TOP or BOTTOM.
// - CPU accesses hit the buffer when buffering, else the active register.
// - Hardware never alters compare values; high byte reads bypass the latch.
// - High byte write fills shared latch; low byte write loads all sixteen bits.
// - Non-PWM force strobe updates output state only, no flag, no counter effect.
// - A counter write blocks every compare match in the next timer tick.
// - Writing counter equal to TOP loses that match; avoid such writes.
// - Output state keeps its value across waveform mode changes.
// - Output action bits are unbuffered; pin override changes immediately.
// - New action settings govern from the next match; force applies at once.
// - Reset clears each channel's output state to zero.
// - Nonzero action bits make the output state replace the port value.
// - Output state reaches the pin only when direction selects output.
// - Action zero leaves the output state unchanged on a match.
// - Action bits do not touch input capture logic.
// - Mode 0 normal, 4 and 12 clear-on-match; these bypass buffering.
module t16oc_top #(
  parameter int W = 16,
  parameter int NCH = 2
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [W-1:0] counter_value,
  input wire logic timer_tick,
  input wire logic counter_written,
  input wire logic counting_down,
  input wire logic at_top,
  input wire logic at_bottom,
  input wire logic [NCH-1:0] port_value,
  input wire logic [NCH-1:0] irq_ack,
  output logic [NCH-1:0] irq_req,
  output logic top_match_a,
  output logic [W-1:0] compare_top_a,
  output logic [NCH-1:0] pin_out,
  output logic [NCH-1:0] pin_oe
);

  logic [7:0] reg_addr;
  logic reg_wr;
  logic [31:0] reg_rdata;
  logic [t16oc_pkg::CTRL_W-1:0] ctrl;
  logic [7:0] high_latch;
  logic block_pend;
  logic match_blocked;
  logic [3:0] mode;
  logic pwm;
  logic [NCH-1:0] irq_en;
  logic [NCH-1:0] pin_dir;
  logic [NCH-1:0] force_match;
  logic [NCH-1:0] flag_clear;
  logic [NCH-1:0] load_en;
  logic [W-1:0] load_value;
  logic [NCH-1:0] match;
  logic [NCH-1:0] flag;
  logic [NCH-1:0] oc_state;
  logic [1:0] action [NCH];
  logic [W-1:0] cmp_active [NCH];
  logic [W-1:0] cmp_view [NCH];
  logic [NCH-1:0] next_pin_out;

  t16oc_ahb_slave u_slave (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_rdata(reg_rdata)
  );

  assign mode = ctrl[t16oc_pkg::CTRL_MODE_LSB +: 4];
  assign pwm = t16oc_pkg::is_pwm(mode);
  assign irq_en = ctrl[t16oc_pkg::CTRL_IRQEN_LSB +: NCH];
  assign pin_dir = ctrl[t16oc_pkg::CTRL_DIR_LSB +: NCH];

  // Write side strobes, one cycle each, in the data phase
  always_comb begin
    force_match = '0;
    flag_clear = '0;
    load_en = '0;
    if (reg_wr) begin
      unique case (reg_addr)
        t16oc_pkg::OFS_FORCE: force_match = hwdata[NCH-1:0];
        t16oc_pkg::OFS_FLAGS: flag_clear = hwdata[NCH-1:0];
        t16oc_pkg::OFS_CMPA_LOW: load_en[0] = 1'b1;
        t16oc_pkg::OFS_CMPB_LOW: load_en[1] = 1'b1;
        default: ;
      endcase
    end
  end

  // Low byte write takes the upper byte from the shared latch in the same cycle
  assign load_value = {high_latch, hwdata[7:0]};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      high_latch <= 8'h00;
    end else if (reg_wr && (reg_addr == t16oc_pkg::OFS_CMPA_HIGH ||
                            reg_addr == t16oc_pkg::OFS_CMPB_HIGH)) begin
      high_latch <= hwdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= t16oc_pkg::CTRL_RESET;
    end else if (reg_wr && reg_addr == t16oc_pkg::OFS_CTRL) begin
      ctrl <= hwdata[t16oc_pkg::CTRL_W-1:0];
    end
  end

  // Held until the next tick so a stopped timer still loses its next match;
  // the same blocking hides a TOP match when the counter is written to TOP
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      block_pend <= 1'b0;
    end else begin
      block_pend <= counter_written || (block_pend && !timer_tick);
    end
  end

  // A write in the tick's own cycle must block that tick as well
  assign match_blocked = block_pend || counter_written;

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      // Action bits feed only this channel, never the capture path
      assign action[gi] = ctrl[t16oc_pkg::CTRL_ACT_LSB + 2*gi +: 2];
      t16oc_channel #(.W(W)) u_ch (
        .hclk(hclk),
        .hresetn(hresetn),
        .counter_value(counter_value),
        .timer_tick(timer_tick),
        .match_block(match_blocked),
        .mode(mode),
        .action(action[gi]),
        .force_match(force_match[gi]),
        .load_en(load_en[gi]),
        .load_value(load_value),
        .at_top(at_top),
        .at_bottom(at_bottom),
        .counting_down(counting_down),
        .flag_clear(flag_clear[gi]),
        .irq_ack(irq_ack[gi]),
        .irq_enable(irq_en[gi]),
        .compare_value(cmp_active[gi]),
        .cpu_view(cmp_view[gi]),
        .match(match[gi]),
        .flag(flag[gi]),
        .irq_req(irq_req[gi]),
        .oc_state(oc_state[gi])
      );
      // Zero action keeps the port's own value and leaves the state alone
      assign next_pin_out[gi] = (action[gi] != t16oc_pkg::ACT_NONE) ?
                                oc_state[gi] : port_value[gi];
    end
  endgenerate

  assign compare_top_a = cmp_active[0];
  assign top_match_a = match[0] && t16oc_pkg::top_is_a(mode) && !match_blocked;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_out <= '0;
      pin_oe <= '0;
    end else begin
      pin_out <= next_pin_out;
      pin_oe <= pin_dir;
    end
  end

  // High byte reads come straight from the register, not the latch
  always_comb begin
    reg_rdata = 32'h0000_0000;
    unique case (reg_addr)
      t16oc_pkg::OFS_CTRL: reg_rdata[t16oc_pkg::CTRL_W-1:0] = ctrl;
      t16oc_pkg::OFS_FLAGS: reg_rdata[NCH-1:0] = flag;
      t16oc_pkg::OFS_STATUS: begin
        reg_rdata[NCH-1:0] = match;
        reg_rdata[t16oc_pkg::STATUS_STATE_LSB +: NCH] = oc_state;
      end
      t16oc_pkg::OFS_CMPA_LOW: reg_rdata[7:0] = cmp_view[0][7:0];
      t16oc_pkg::OFS_CMPA_HIGH: reg_rdata[7:0] = cmp_view[0][15:8];
      t16oc_pkg::OFS_CMPB_LOW: reg_rdata[7:0] = cmp_view[1][7:0];
      t16oc_pkg::OFS_CMPB_HIGH: reg_rdata[7:0] = cmp_view[1][15:8];
      default: reg_rdata = 32'h0000_0000;
    endcase
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_match_equal;
    match[0] == (counter_value == cmp_active[0]);
  endproperty
  a_match_equal: assert property (p_match_equal) else $error("match A wrong");

  property p_flag_after_tick;
    $rose(flag[0]) |-> $past(timer_tick) && !$past(block_pend, 2);
  endproperty
  a_flag_after_tick: assert property (p_flag_after_tick)
    else $error("flag A rose without tick");

  property p_irq_level;
    irq_req[0] == (flag[0] && ctrl[t16oc_pkg::CTRL_IRQEN_LSB]);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq A wrong");

  property p_ack_clears;
    irq_ack[0] && !timer_tick |=> !flag[0];
  endproperty
  a_ack_clears: assert property (p_ack_clears) else $error("ack kept flag A");

  property p_clear_one;
    flag_clear[1] && !timer_tick |=> !flag[1];
  endproperty
  a_clear_one: assert property (p_clear_one) else $error("clear kept flag B");

  property p_clear_zero;
    reg_wr && reg_addr == t16oc_pkg::OFS_FLAGS && !hwdata[0] && flag[0] && !irq_ack[0]
      |=> flag[0];
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("zero write cleared A");

  property p_direct_load;
    load_en[0] && !pwm |=> cmp_active[0] == {$past(high_latch), $past(hwdata[7:0])};
  endproperty
  a_direct_load: assert property (p_direct_load) else $error("direct load wrong");

  property p_buffer_hold;
    pwm && !timer_tick && $stable(ctrl) |=> $stable(cmp_active[1]);
  endproperty
  a_buffer_hold: assert property (p_buffer_hold) else $error("active B moved");

  property p_force_no_flag;
    force_match[0] && !flag[0] && !timer_tick |=> !flag[0];
  endproperty
  a_force_no_flag: assert property (p_force_no_flag) else $error("force set flag");

  property p_block_held;
    counter_written || (block_pend && !timer_tick) |=> block_pend;
  endproperty
  a_block_held: assert property (p_block_held) else $error("block dropped");

  property p_override;
    action[0] != t16oc_pkg::ACT_NONE |=> pin_out[0] == $past(oc_state[0]);
  endproperty
  a_override: assert property (p_override) else $error("pin A not overridden");

  property p_dir;
    ##1 pin_oe[0] == $past(pin_dir[0]);
  endproperty
  a_dir: assert property (p_dir) else $error("pin A enable wrong");

  property p_hit_sets_flag;
    g_ch[0].u_ch.hit |=> flag[0];
  endproperty
  a_hit_sets_flag: assert property (p_hit_sets_flag)
    else $error("hit did not set flag A");

  property p_set_wins;
    g_ch[0].u_ch.hit && (flag_clear[0] || irq_ack[0]) |=> flag[0];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("clear beat set on flag A");

  property p_force_set;
    force_match[0] && !pwm && action[0] == t16oc_pkg::ACT_SET |=> oc_state[0];
  endproperty
  a_force_set: assert property (p_force_set)
    else $error("force did not set state A");

  property p_view_direct;
    !pwm |-> cmp_view[0] == cmp_active[0];
  endproperty
  a_view_direct: assert property (p_view_direct)
    else $error("cpu view A not active");

  property p_top_equal;
    top_match_a |-> counter_value == compare_top_a;
  endproperty
  a_top_equal: assert property (p_top_equal)
    else $error("top match without equality");

  property p_top_blocked;
    match_blocked |-> !top_match_a;
  endproperty
  a_top_blocked: assert property (p_top_blocked)
    else $error("blocked top match seen");

  property p_cmp_hold;
    !load_en[0] && !timer_tick |=> $stable(cmp_active[0]);
  endproperty
  a_cmp_hold: assert property (p_cmp_hold)
    else $error("active A changed by itself");

  property p_latch_hold;
    !reg_wr |=> $stable(high_latch);
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("high latch moved");

  property p_pwm_no_force;
    pwm && !timer_tick |=> $stable(oc_state[0]);
  endproperty
  a_pwm_no_force: assert property (p_pwm_no_force)
    else $error("state A moved in PWM");

  property p_mode_keeps;
    reg_wr && reg_addr == t16oc_pkg::OFS_CTRL && !timer_tick |=> $stable(oc_state[0]);
  endproperty
  a_mode_keeps: assert property (p_mode_keeps)
    else $error("control write moved state A");

  property p_zero_action;
    action[0] == t16oc_pkg::ACT_NONE |=> $stable(oc_state[0]);
  endproperty
  a_zero_action: assert property (p_zero_action)
    else $error("zero action moved state A");

  property p_port_pass;
    action[0] == t16oc_pkg::ACT_NONE |=> pin_out[0] == $past(port_value[0]);
  endproperty
  a_port_pass: assert property (p_port_pass)
    else $error("pin A lost port value");

endmodule : t16oc_top

//--- inc/t16oc_pkg.sv
// Shared constants, types and mode decoding for the timer output compare block
package t16oc_pkg;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FORCE = 8'h04;
  localparam logic [7:0] OFS_FLAGS = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_CMPA_LOW = 8'h10;
  localparam logic [7:0] OFS_CMPA_HIGH = 8'h14;
  localparam logic [7:0] OFS_CMPB_LOW = 8'h18;
  localparam logic [7:0] OFS_CMPB_HIGH = 8'h1C;

  localparam int CTRL_W = 12;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_ACT_LSB = 4;
  localparam int CTRL_IRQEN_LSB = 8;
  localparam int CTRL_DIR_LSB = 10;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 12'h000;
  localparam int STATUS_STATE_LSB = 2;

  localparam logic [3:0] MODE_NORMAL = 4'h0;
  localparam logic [3:0] MODE_CTC_A = 4'h4;
  localparam logic [3:0] MODE_CTC_CAP = 4'hC;
  localparam logic [3:0] MODE_RESERVED = 4'hD;

  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;

  typedef enum logic [1:0] {
    SL_IDLE = 2'b00,
    SL_WR = 2'b01,
    SL_RD_WAIT = 2'b11,
    SL_RD_DONE = 2'b10
  } t16oc_slave_state_t;

  // Twelve PWM modes: all but normal, the two clear-on-match modes and reserved
  function automatic logic is_pwm(input logic [3:0] mode);
    is_pwm = !(mode == MODE_NORMAL || mode == MODE_CTC_A || mode == MODE_CTC_CAP ||
               mode == MODE_RESERVED);
  endfunction : is_pwm

  // Fast PWM is single slope
  function automatic logic is_fast(input logic [3:0] mode);
    is_fast = (mode == 4'h5) || (mode == 4'h6) || (mode == 4'h7) || (mode == 4'hE) ||
              (mode == 4'hF);
  endfunction : is_fast

  // Buffered value moves at BOTTOM in fast and phase-frequency modes, else at TOP
  function automatic logic update_at_bottom(input logic [3:0] mode);
    update_at_bottom = is_fast(mode) || (mode == 4'h8) || (mode == 4'h9);
  endfunction : update_at_bottom

  // Modes in which channel A's compare value is the counter TOP
  function automatic logic top_is_a(input logic [3:0] mode);
    top_is_a = (mode == MODE_CTC_A) || (mode == 4'h9) || (mode == 4'hB) || (mode == 4'hF);
  endfunction : top_is_a

endpackage : t16oc_pkg

//--- logic/t16oc_ahb_slave.sv
// AHB-Lite slave front end: address phase capture, write strobe, one-wait read
`timescale 1ns/10ps
module t16oc_ahb_slave (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  input wire logic [31:0] reg_rdata
);

  t16oc_pkg::t16oc_slave_state_t state;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= t16oc_pkg::SL_IDLE;
      reg_addr <= 8'h00;
    end else if (hready) begin
      if (hsel && htrans[1]) begin
        state <= hwrite ? t16oc_pkg::SL_WR : t16oc_pkg::SL_RD_WAIT;
        reg_addr <= haddr[7:0];
      end else begin
        state <= t16oc_pkg::SL_IDLE;
      end
    end else if (state == t16oc_pkg::SL_RD_WAIT) begin
      state <= t16oc_pkg::SL_RD_DONE;
    end
  end

  // Wait state lets a write in the previous data phase land before read data is taken
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (state == t16oc_pkg::SL_RD_WAIT) begin
      hrdata <= reg_rdata;
    end
  end

  assign hreadyout = (state != t16oc_pkg::SL_RD_WAIT);
  assign hresp = 1'b0;
  assign reg_wr = (state == t16oc_pkg::SL_WR);

endmodule : t16oc_ahb_slave

//--- logic/t16oc_channel.sv
// One compare channel: comparator, double buffer, flag and output state
`timescale 1ns/10ps
module t16oc_channel #(
  parameter int W = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [W-1:0] counter_value,
  input wire logic timer_tick,
  input wire logic match_block,
  input wire logic [3:0] mode,
  input wire logic [1:0] action,
  input wire logic force_match,
  input wire logic load_en,
  input wire logic [W-1:0] load_value,
  input wire logic at_top,
  input wire logic at_bottom,
  input wire logic counting_down,
  input wire logic flag_clear,
  input wire logic irq_ack,
  input wire logic irq_enable,
  output logic [W-1:0] compare_value,
  output logic [W-1:0] cpu_view,
  output logic match,
  output logic flag,
  output logic irq_req,
  output logic oc_state
);

  logic [W-1:0] buffer_value;
  logic match_q;
  logic hit;
  logic pwm;
  logic upd_point;

  // Non-PWM: 1 toggles, 2 clears, 3 sets; PWM sense flips when counting down
  function automatic logic apply(input logic [1:0] act, input logic cur,
                                 input logic inv);
    logic r;
    r = cur;
    unique case (act)
      t16oc_pkg::ACT_NONE: r = cur;
      t16oc_pkg::ACT_TOGGLE: r = ~cur;
      t16oc_pkg::ACT_CLEAR: r = inv;
      t16oc_pkg::ACT_SET: r = ~inv;
    endcase
    apply = r;
  endfunction : apply

  assign pwm = t16oc_pkg::is_pwm(mode);
  assign upd_point = t16oc_pkg::update_at_bottom(mode) ? at_bottom : at_top;
  assign match = (counter_value == compare_value);
  assign hit = timer_tick && match_q;
  assign cpu_view = pwm ? buffer_value : compare_value;
  assign irq_req = flag && irq_enable;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      buffer_value <= '0;
    end else if (load_en) begin
      buffer_value <= load_value;
    end
  end

  // Only CPU loads or the buffer transfer ever change the active value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      compare_value <= '0;
    end else if (load_en && !pwm) begin
      compare_value <= load_value;
    end else if (pwm && timer_tick && upd_point) begin
      compare_value <= buffer_value;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      match_q <= 1'b0;
    end else if (timer_tick) begin
      match_q <= match && !match_block;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag <= 1'b0;
    end else begin
      flag <= (flag && !(flag_clear || irq_ack)) || hit;
    end
  end

  // No reset on mode change, so the state carries across modes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      oc_state <= 1'b0;
    end else if (force_match && !pwm) begin
      oc_state <= apply(action, oc_state, 1'b0);
    end else if (hit) begin
      oc_state <= apply(action, oc_state, pwm && counting_down);
    end else if (pwm && t16oc_pkg::is_fast(mode) && timer_tick && at_bottom &&
                 action[1]) begin
      oc_state <= ~action[0];
    end
  end

endmodule : t16oc_channel

//--- sim/t16oc_counter_model.sv
// Behavioural counter unit that feeds the compare block: prescaled tick, load, TOP and BOTTOM
`timescale 1ns/10ps
module t16oc_counter_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic run,
  input wire logic load,
  input wire logic [15:0] load_value,
  input wire logic [15:0] top_value,
  output logic [15:0] counter_value,
  output logic timer_tick,
  output logic counter_written,
  output logic at_top,
  output logic at_bottom,
  output logic counting_down
);
  logic [1:0] div;

  // Prescale by four so ticks are sparse against bus traffic
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div <= 2'h0;
    end else if (run) begin
      div <= div + 2'h1;
    end
  end

  assign timer_tick = run && (div == 2'h3);

  // A load wins over counting, as a CPU write does
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      counter_value <= 16'h0000;
    end else if (load) begin
      counter_value <= load_value;
    end else if (timer_tick) begin
      counter_value <= at_top ? 16'h0000 : counter_value + 16'h0001;
    end
  end

  // Pulse marks the cycle the loaded value shows
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      counter_written <= 1'b0;
    end else begin
      counter_written <= load;
    end
  end

  assign at_top = (counter_value == top_value);
  assign at_bottom = (counter_value == 16'h0000);
  // Single slope only; down counting is not modelled
  assign counting_down = 1'b0;
endmodule : t16oc_counter_model

//--- sim/t16oc_top_bench.sv
// Self-checking bench for the timer output compare block over AHB-Lite
`timescale 1ns/10ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin n_errors++; \
  $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp); end end
module t16oc_top_bench;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [1:0] htrans, port_value, irq_ack, irq_req, pin_out, pin_oe;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [15:0] counter_value, compare_top_a, load_value, top_value;
  logic timer_tick, counter_written, counting_down, at_top, at_bottom, top_match_a;
  logic run, load;
  int n_errors = 0;
  int checked = 0;
  logic [1:0] acts [5] = '{2'h3, 2'h0, 2'h2, 2'h1, 2'h1};
  logic exps [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
  logic [3:0] modes [3] = '{t16oc_pkg::MODE_NORMAL, t16oc_pkg::MODE_CTC_A,
                            t16oc_pkg::MODE_CTC_CAP};

  assign hready = hreadyout;

  t16oc_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .counter_value(counter_value),
    .timer_tick(timer_tick), .counter_written(counter_written),
    .counting_down(counting_down), .at_top(at_top), .at_bottom(at_bottom),
    .port_value(port_value), .irq_ack(irq_ack), .irq_req(irq_req),
    .top_match_a(top_match_a), .compare_top_a(compare_top_a), .pin_out(pin_out),
    .pin_oe(pin_oe));

  t16oc_counter_model CNT (.hclk(hclk), .hresetn(hresetn), .run(run), .load(load),
    .load_value(load_value), .top_value(top_value), .counter_value(counter_value),
    .timer_tick(timer_tick), .counter_written(counter_written), .at_top(at_top),
    .at_bottom(at_bottom), .counting_down(counting_down));

  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test

  // Ready is looked at where it settles, before the edge that samples it
  task automatic wait_ready(output logic [31:0] rd);
    logic r;
    do begin
      @(negedge hclk);
      r = hready;
      rd = hrdata;
      @(posedge hclk);
    end while (r !== 1'b1);
  endtask : wait_ready

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    wait_ready(rd);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready(rd);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] x;
    bus(1'b1, a, wd, x);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] x);
    bus(1'b0, a, 32'h00000000, x);
  endtask : rd

  task automatic ctrl(input logic [3:0] m, input logic [1:0] act, input logic irq,
                      input logic dir);
    wr(t16oc_pkg::OFS_CTRL, {20'h00000, 1'b0, dir, 1'b0, irq, 2'h0, act, m});
  endtask : ctrl

  // High byte first through the shared latch, then the low byte loads all sixteen bits
  task automatic set_cmp(input logic ch, input logic [15:0] v);
    wr(ch ? t16oc_pkg::OFS_CMPB_HIGH : t16oc_pkg::OFS_CMPA_HIGH, {24'h000000, v[15:8]});
    wr(ch ? t16oc_pkg::OFS_CMPB_LOW : t16oc_pkg::OFS_CMPA_LOW, {24'h000000, v[7:0]});
  endtask : set_cmp

  task automatic load_cnt(input logic [15:0] v);
    @(posedge hclk);
    load <= 1'b1;
    load_value <= v;
    @(posedge hclk);
    load <= 1'b0;
  endtask : load_cnt

  // Run up through the compare value 0x0100 and stop once the request shows
  task automatic wait_match;
    load_cnt(16'h00FD);
    run <= 1'b1;
    for (int n = 0; n < 80 && irq_req[0] !== 1'b1; n++) @(posedge hclk);
    run <= 1'b0;
    `CHK(irq_req[0], 1'b1)
  endtask : wait_match

  initial begin
    repeat (20000) @(posedge hclk);
    n_errors++;
    $display("[FAIL] %0t ns: watchdog expired", $time);
    finish_test();
  end

  initial begin
    hresetn = 1'b0;
    {hsel, hwrite, run, load} = 4'h0;
    htrans = 2'h0;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    load_value = 16'h0000;
    top_value = 16'hFFFF;
    port_value = 2'b10;
    irq_ack = 2'b00;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    rd(t16oc_pkg::OFS_CTRL, d);
    `CHK(d[11:0], t16oc_pkg::CTRL_RESET)
    rd(t16oc_pkg::OFS_STATUS, d);
    `CHK(d[3:2], 2'b00)
    rd(8'h20, d);
    `CHK(d, 32'h00000000)
    `CHK({hresp, pin_oe, irq_req}, 5'h00)
    $display("Reset test done");

    foreach (modes[i]) begin
      ctrl(modes[i], 2'h0, 1'b0, 1'b0);
      set_cmp(1'b0, 16'h1200 + 16'(i));
      @(negedge hclk);
      `CHK(compare_top_a, 16'h1200 + 16'(i))
      rd(t16oc_pkg::OFS_CMPA_HIGH, d);
      `CHK(d[7:0], 8'h12)
    end
    set_cmp(1'b1, 16'h0ABC);
    rd(t16oc_pkg::OFS_CMPB_LOW, d);
    `CHK(d[7:0], 8'hBC)
    rd(t16oc_pkg::OFS_CMPB_HIGH, d);
    `CHK(d[7:0], 8'h0A)
    $display("Direct compare access test done");

    ctrl(t16oc_pkg::MODE_NORMAL, 2'h0, 1'b1, 1'b0);
    set_cmp(1'b0, 16'h0100);
    load_cnt(16'h0100);
    run <= 1'b1;
    repeat (12) @(posedge hclk);
    run <= 1'b0;
    rd(t16oc_pkg::OFS_FLAGS, d);
    `CHK(d[1:0], 2'b00)
    wait_match();
    rd(t16oc_pkg::OFS_FLAGS, d);
    `CHK(d[1:0], 2'b01)
    wr(t16oc_pkg::OFS_FLAGS, 32'h00000000);
    rd(t16oc_pkg::OFS_FLAGS, d);
    `CHK(d[0], 1'b1)
    @(posedge hclk);
    irq_ack <= 2'b01;
    @(posedge hclk);
    irq_ack <= 2'b00;
    rd(t16oc_pkg::OFS_FLAGS, d);
    `CHK(d[0], 1'b0)
    wait_match();
    wr(t16oc_pkg::OFS_FLAGS, 32'h00000003);
    rd(t16oc_pkg::OFS_FLAGS, d);
    `CHK(d[0], 1'b0)
    `CHK(irq_req[0], 1'b0)
    $display("Flag and interrupt test done");

    // Output state set up before the pin is driven
    ctrl(t16oc_pkg::MODE_NORMAL, t16oc_pkg::ACT_SET, 1'b0, 1'b0);
    wr(t16oc_pkg::OFS_FORCE, 32'h00000001);
    `CHK(pin_oe[0], 1'b0)
    foreach (acts[i]) begin
      ctrl(t16oc_pkg::MODE_NORMAL, acts[i], 1'b0, 1'b1);
      wr(t16oc_pkg::OFS_FORCE, 32'h00000001);
      rd(t16oc_pkg::OFS_STATUS, d);
      `CHK(d[t16oc_pkg::STATUS_STATE_LSB], exps[i])
      `CHK(pin_out[0], (acts[i] != 2'h0) ? exps[i] : port_value[0])
      `CHK(pin_oe[0], 1'b1)
      rd(t16oc_pkg::OFS_FLAGS, d);
      `CHK(d[0], 1'b0)
    end
    ctrl(t16oc_pkg::MODE_NORMAL, t16oc_pkg::ACT_SET, 1'b0, 1'b1);
    wr(t16oc_pkg::OFS_FORCE, 32'h00000001);
    ctrl(4'h1, t16oc_pkg::ACT_CLEAR, 1'b0, 1'b1);
    wr(t16oc_pkg::OFS_FORCE, 32'h00000001);
    rd(t16oc_pkg::OFS_STATUS, d);
    `CHK(d[t16oc_pkg::STATUS_STATE_LSB], 1'b1)
    $display("Force and pin test done");

    // Mode 1 buffers; the new value waits for TOP
    set_cmp(1'b0, 16'h0055);
    @(negedge hclk);
    `CHK(compare_top_a, 16'h0100)
    rd(t16oc_pkg::OFS_CMPA_LOW, d);
    `CHK(d[7:0], 8'h55)
    top_value <= 16'h00FF;
    load_cnt(16'h00FE);
    run <= 1'b1;
    repeat (16) @(posedge hclk);
    run <= 1'b0;
    @(negedge hclk);
    `CHK(compare_top_a, 16'h0055)
    $display("Buffered update test done");

    // Counter written onto TOP hides the match until the next tick
    ctrl(t16oc_pkg::MODE_CTC_A, 2'h0, 1'b0, 1'b0);
    load_cnt(16'h0055);
    @(negedge hclk);
    `CHK(top_match_a, 1'b0)
    load_cnt(16'h0054);
    run <= 1'b1;
    do @(negedge hclk); while (counter_value !== 16'h0055);
    @(posedge hclk);
    run <= 1'b0;
    @(negedge hclk);
    `CHK(top_match_a, 1'b1)
    $display("Top match test done");
    finish_test();
  end
endmodule : t16oc_top_bench
